// ---- hdl/smw_cfg.svh ----
/*
 Constants for the sleep and wake controller: register bit positions, timing.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SMW_CFG_SVH
`define SMW_CFG_SVH
`define SMW_CLK_SPD_IDLE_STOP_BIT   10
`define SMW_CLK_SPD_CRYSTAL_BIT     9
`define SMW_CLK_SPD_TRIMMED_BIT     8
`define SMW_INT_GEN_ASYNC_WAKE_BIT  14
`define SMW_DAC_PDO_ENABLE_BIT      2
`define SMW_CLK_SPD_ADDR            8'h3D
`define SMW_INT_GEN_ADDR            8'h38
`define SMW_DAC_CTRL_ADDR           8'h34
`define SMW_CLK_PERIOD_NS           20
`define SMW_CRYSTAL_START_NS        2000
`define SMW_TRIMMED_START_NS        400
`define SMW_CRYSTAL_START_CYC \
   ((`SMW_CRYSTAL_START_NS + `SMW_CLK_PERIOD_NS - 1) / `SMW_CLK_PERIOD_NS)
`define SMW_TRIMMED_START_CYC \
   ((`SMW_TRIMMED_START_NS + `SMW_CLK_PERIOD_NS - 1) / `SMW_CLK_PERIOD_NS)
`define SMW_CNT_W                   12
`define SMW_NUM_PORT_WAKE           12
`endif

// ---- hdl/smw_pkg.sv ----
/*
 Types for the sleep and wake controller.
 Assumes smw_cfg.svh is compiled with it.
*/
`default_nettype none
`include "smw_cfg.svh"
package smw_pkg;
   typedef enum logic [1:0] {SMW_AWAKE, SMW_SLEEP, SMW_SETTLE} smw_state_e;
   typedef enum logic [1:0] {SMW_WAKE_NONE, SMW_WAKE_RESET, SMW_WAKE_VECTOR, SMW_WAKE_RESUME}
      smw_wake_e;
   typedef struct packed {
      logic idle_stop;
      logic crystal_en;
      logic trimmed_en;
      logic async_wake;
      logic pdo_en;
      logic global_int_en;
   } smw_ctrl_s;
   typedef struct packed {
      logic cpu_clk_en;
      logic pll_en;
      logic master_clk_en;
      logic half_mc_timer_run;
      logic ref_timer_run;
   } smw_clk_s;
endpackage : smw_pkg
`default_nettype wire

// ---- hdl/smw_sleep_ctrl.sv ----
/*
 Sleep-mode controller: gates the CPU clock on sleep and PLL, master clock and timers per idle stop and oscillator enables, wakes on reset
 pin rise, masked timer underflow or masked port edge, and on an interrupt wake holds the CPU clock until the
 reference oscillator has restarted.
 Assumes control bits come from registers on ref_clk_i; pins and underflows are asynchronous.
*/
`default_nettype none
`include "smw_cfg.svh"
module smw_sleep_ctrl (
   input  wire logic                           ref_clk_i,
   input  wire logic                           sys_rst_i,
   input  wire logic [15:0]                    clock_speed_control_i,
   input  wire logic [15:0]                    interrupt_general_control_i,
   input  wire logic [15:0]                    dac_control_i,
   input  wire logic                           global_int_en_i,
   input  wire logic [1:0]                     interrupt_mask_timer_i,
   input  wire logic [`SMW_NUM_PORT_WAKE-1:0]  interrupt_mask_port_i,
   input  wire logic [`SMW_NUM_PORT_WAKE-1:0]  port_edge_rise_i,
   input  wire logic [`SMW_NUM_PORT_WAKE-1:0]  port_pin_i,
   input  wire logic [1:0]                     timer_half_mc_src_i,
   input  wire logic [1:0]                     timer_enable_i,
   input  wire logic [1:0]                     timer_underflow_i,
   input  wire logic                           dac_timer_underflow_i,
   input  wire logic                           reset_pin_i,
   input  wire logic                           sleep_cmd_i,
   output smw_pkg::smw_clk_s                   clk_ctrl_o,
   output logic                                asleep_o,
   output smw_pkg::smw_wake_e                  wake_kind_o,
   output logic                                wake_pulse_o
);
   smw_pkg::smw_state_e state;
   smw_pkg::smw_ctrl_s  ctrl;
   smw_pkg::smw_ctrl_s  held;
   smw_pkg::smw_state_e next_state;
   logic [`SMW_CNT_W-1:0] settle_cnt;
   logic [`SMW_CNT_W-1:0] next_settle_cnt;
   logic [`SMW_NUM_PORT_WAKE-1:0] port_rise;
   logic [`SMW_NUM_PORT_WAKE-1:0] port_fall;
   logic [1:0] tmr_pulse;
   logic [1:0] unused_tmr_fall;
   logic [1:0] unused_tmr_lvl;
   logic [`SMW_NUM_PORT_WAKE-1:0] unused_port_lvl;
   logic rst_rise;
   logic rst_fall;
   logic rst_lvl;
   logic dac_rise;
   logic dac_fall;
   logic dac_lvl;
   logic port_wake;
   logic timer_wake;
   logic int_wake;
   logic mid_or_deep;
   logic ref_on;

   // Control bit extraction
   always_comb begin
      ctrl.idle_stop     = clock_speed_control_i[`SMW_CLK_SPD_IDLE_STOP_BIT];
      ctrl.crystal_en    = clock_speed_control_i[`SMW_CLK_SPD_CRYSTAL_BIT];
      ctrl.trimmed_en    = clock_speed_control_i[`SMW_CLK_SPD_TRIMMED_BIT];
      ctrl.async_wake    = interrupt_general_control_i[`SMW_INT_GEN_ASYNC_WAKE_BIT];
      ctrl.pdo_en        = dac_control_i[`SMW_DAC_PDO_ENABLE_BIT];
      ctrl.global_int_en = global_int_en_i;
   end

   smw_sync u_rst_sync (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (reset_pin_i),
      .level_o   (rst_lvl),
      .rise_o    (rst_rise),
      .fall_o    (rst_fall)
   );

   smw_sync u_dac_sync (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (dac_timer_underflow_i),
      .level_o   (dac_lvl),
      .rise_o    (dac_rise),
      .fall_o    (dac_fall)
   );

   genvar gi;
   generate
      for (gi = 0; gi < `SMW_NUM_PORT_WAKE; gi = gi + 1) begin : g_port
         smw_sync u_port_sync (
            .ref_clk_i (ref_clk_i),
            .sys_rst_i (sys_rst_i),
            .async_i   (port_pin_i[gi]),
            .level_o   (unused_port_lvl[gi]),
            .rise_o    (port_rise[gi]),
            .fall_o    (port_fall[gi])
         );
      end
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_tmr
         smw_sync u_tmr_sync (
            .ref_clk_i (ref_clk_i),
            .sys_rst_i (sys_rst_i),
            .async_i   (timer_underflow_i[gi]),
            .level_o   (unused_tmr_lvl[gi]),
            .rise_o    (tmr_pulse[gi]),
            .fall_o    (unused_tmr_fall[gi])
         );
      end
   endgenerate

   // Wake qualification from settings held at sleep entry
   always_comb begin
      mid_or_deep = held.idle_stop;
      ref_on      = held.crystal_en | held.trimmed_en;
      port_wake   = |(interrupt_mask_port_i & ((port_rise & port_edge_rise_i) |
                    (port_fall & ~port_edge_rise_i)));
      timer_wake  = 1'b0;
      for (int i = 0; i < 2; i++) begin
         if (tmr_pulse[i] & interrupt_mask_timer_i[i] & timer_enable_i[i] &
             ((timer_half_mc_src_i[i] & ~mid_or_deep) |
              (~timer_half_mc_src_i[i] & ref_on))) begin
            timer_wake = 1'b1;
         end
      end
      // Stop bit set needs async wake for any interrupt; DAC underflow never wakes
      int_wake = (port_wake | timer_wake) & (~mid_or_deep | held.async_wake);
   end

   // Sleep sequencing
   always_comb begin
      next_state      = state;
      next_settle_cnt = settle_cnt;
      unique case (state)
         smw_pkg::SMW_AWAKE: begin
            if (sleep_cmd_i) begin
               next_state = smw_pkg::SMW_SLEEP;
            end
         end
         smw_pkg::SMW_SLEEP: begin
            if (rst_rise) begin
               next_state = smw_pkg::SMW_AWAKE;
            end else if (int_wake) begin
               next_state = smw_pkg::SMW_SETTLE;
               if (~ref_on | mid_or_deep) begin
                  next_settle_cnt = held.crystal_en ? `SMW_CNT_W'(`SMW_CRYSTAL_START_CYC) :
                                    `SMW_CNT_W'(`SMW_TRIMMED_START_CYC);
               end else begin
                  next_settle_cnt = '0;
               end
            end
         end
         smw_pkg::SMW_SETTLE: begin
            if (rst_rise) begin
               next_state = smw_pkg::SMW_AWAKE;
            end else if (settle_cnt == '0) begin
               next_state = smw_pkg::SMW_AWAKE;
            end else begin
               next_settle_cnt = settle_cnt - `SMW_CNT_W'(1);
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state      <= smw_pkg::SMW_AWAKE;
         settle_cnt <= '0;
      end else begin
         state      <= next_state;
         settle_cnt <= next_settle_cnt;
      end
   end

   // Settings captured at the sleep command
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         held <= '0;
      end else if (state == smw_pkg::SMW_AWAKE && sleep_cmd_i) begin
         held <= ctrl;
      end
   end

   // Clock gating outputs, registered
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         clk_ctrl_o <= '{cpu_clk_en: 1'b1, pll_en: 1'b1, master_clk_en: 1'b1,
                         half_mc_timer_run: 1'b1, ref_timer_run: 1'b1};
      end else if (next_state == smw_pkg::SMW_AWAKE) begin
         clk_ctrl_o <= '{cpu_clk_en: 1'b1, pll_en: 1'b1, master_clk_en: 1'b1,
                         half_mc_timer_run: 1'b1, ref_timer_run: 1'b1};
      end else if (next_state == smw_pkg::SMW_SLEEP) begin
         clk_ctrl_o.cpu_clk_en <= 1'b0;
         clk_ctrl_o.pll_en <= state == smw_pkg::SMW_AWAKE ? ~ctrl.idle_stop :
                              ~held.idle_stop;
         clk_ctrl_o.master_clk_en <= state == smw_pkg::SMW_AWAKE ? ~ctrl.idle_stop :
                                     ~held.idle_stop;
         clk_ctrl_o.half_mc_timer_run <= state == smw_pkg::SMW_AWAKE ? ~ctrl.idle_stop :
                                         ~held.idle_stop;
         clk_ctrl_o.ref_timer_run <= state == smw_pkg::SMW_AWAKE ?
                                     (ctrl.crystal_en | ctrl.trimmed_en) : ref_on;
      end else begin
         clk_ctrl_o.cpu_clk_en    <= 1'b0;
         clk_ctrl_o.pll_en        <= 1'b1;
         clk_ctrl_o.master_clk_en <= 1'b0;
      end
   end

   // Wake report
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         asleep_o     <= 1'b0;
         wake_kind_o  <= smw_pkg::SMW_WAKE_NONE;
         wake_pulse_o <= 1'b0;
      end else begin
         asleep_o     <= next_state != smw_pkg::SMW_AWAKE;
         wake_pulse_o <= state != smw_pkg::SMW_AWAKE && next_state == smw_pkg::SMW_AWAKE;
         if (state != smw_pkg::SMW_AWAKE && rst_rise) begin
            wake_kind_o <= smw_pkg::SMW_WAKE_RESET;
         end else if (state == smw_pkg::SMW_SLEEP && int_wake) begin
            wake_kind_o <= held.global_int_en ? smw_pkg::SMW_WAKE_VECTOR :
                           smw_pkg::SMW_WAKE_RESUME;
         end else if (state == smw_pkg::SMW_AWAKE && sleep_cmd_i) begin
            wake_kind_o <= smw_pkg::SMW_WAKE_NONE;
         end
      end
   end

   logic unused_ok;
   assign unused_ok = rst_lvl ^ rst_fall ^ dac_lvl ^ dac_rise ^ dac_fall ^ held.pdo_en ^
                      (|unused_tmr_fall) ^ (|unused_tmr_lvl) ^ (|unused_port_lvl);
endmodule // smw_sleep_ctrl
`default_nettype wire

// ---- hdl/smw_sync.sv ----
/*
 Two flip-flop synchroniser with rising and falling edge detect after stage two.
 Assumes an asynchronous input; edges are one-cycle pulses.
*/
`default_nettype none
module smw_sync (
   input  wire logic ref_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic async_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);
   logic meta;
   logic sync;
   logic last;
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta <= 1'b0;
         sync <= 1'b0;
         last <= 1'b0;
      end else begin
         meta <= async_i;
         sync <= meta;
         last <= sync;
      end
   end
   assign level_o = sync;
   assign rise_o  = sync & ~last;
   assign fall_o  = ~sync & last;
endmodule // smw_sync
`default_nettype wire

// ---- test/smw_sleep_ctrl_sva.sv ----
/* Assertions on the sleep and wake controller ports.
   Assumes one clock domain, ref_clk_i, with sys_rst_i as reset. */
`default_nettype none
module smw_sleep_ctrl_sva (
   input wire logic               ref_clk_i,
   input wire logic               sys_rst_i,
   input wire logic [15:0]        clock_speed_control_i,
   input wire logic               reset_pin_i,
   input wire logic               sleep_cmd_i,
   input wire smw_pkg::smw_clk_s  clk_ctrl_o,
   input wire logic               asleep_o,
   input wire smw_pkg::smw_wake_e wake_kind_o,
   input wire logic               wake_pulse_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_sleep_taken;
      !asleep_o && sleep_cmd_i;
   endsequence
   sequence s_gated;
      asleep_o && !clk_ctrl_o.cpu_clk_en;
   endsequence
   a_sleep_gates_cpu: assert property (s_sleep_taken |=> s_gated)
      else $error("cpu clock not gated on sleep");
   a_pll_by_stop: assert property (s_sleep_taken |=>
      clk_ctrl_o.pll_en == !$past(clock_speed_control_i[10]))
      else $error("pll state does not follow idle stop");
   a_ref_timer_run: assert property (s_sleep_taken |=>
      clk_ctrl_o.ref_timer_run ==
      ($past(clock_speed_control_i[9]) | $past(clock_speed_control_i[8])))
      else $error("reference timer state wrong");
   a_reset_pin_wakes: assert property (asleep_o && $rose(reset_pin_i) |->
      ##[1:5] (!asleep_o && wake_kind_o == smw_pkg::SMW_WAKE_RESET))
      else $error("reset pin rise did not wake");
   a_held_gated: assert property (asleep_o |-> !clk_ctrl_o.cpu_clk_en)
      else $error("cpu clock running while asleep");
   a_awake_all_run: assert property (!asleep_o |-> clk_ctrl_o == 5'h1F)
      else $error("clock gated while awake");
   a_pulse_on_return: assert property (wake_pulse_o |->
      $past(asleep_o) && !asleep_o ##1 !wake_pulse_o)
      else $error("wake pulse wrong");
   a_mc_needs_pll: assert property (clk_ctrl_o.master_clk_en |-> clk_ctrl_o.pll_en)
      else $error("master clock without pll");
   a_kind_holds: assert property (!asleep_o && !sleep_cmd_i |=> $stable(wake_kind_o))
      else $error("wake kind changed while awake");
endmodule // smw_sleep_ctrl_sva
bind smw_sleep_ctrl smw_sleep_ctrl_sva u_sva (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
   .clock_speed_control_i(clock_speed_control_i), .reset_pin_i(reset_pin_i),
   .sleep_cmd_i(sleep_cmd_i), .clk_ctrl_o(clk_ctrl_o), .asleep_o(asleep_o),
   .wake_kind_o(wake_kind_o), .wake_pulse_o(wake_pulse_o));
`default_nettype wire

// ---- test/test_sleep_mode_wake_control.sv ----
/* Self-checking bench for the sleep and wake controller.
   Assumes the checker is bound in; drives all ports at the rising edge. */
`default_nettype none
module test_sleep_mode_wake_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic              ref_clk, sys_rst, glb, dac_uf, rst_pin, cmd, asl, pls;
   logic [15:0]       cs, igc, dac;
   logic [1:0]        msk_t, src, ten, uf;
   logic [11:0]       msk_p, rise, pin;
   smw_pkg::smw_clk_s  clk_o;
   smw_pkg::smw_wake_e kind;
   int                err_total, check_count;
   smw_sleep_ctrl DUT (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .clock_speed_control_i(cs),
      .interrupt_general_control_i(igc), .dac_control_i(dac), .global_int_en_i(glb),
      .interrupt_mask_timer_i(msk_t), .interrupt_mask_port_i(msk_p), .port_edge_rise_i(rise),
      .port_pin_i(pin), .timer_half_mc_src_i(src), .timer_enable_i(ten),
      .timer_underflow_i(uf), .dac_timer_underflow_i(dac_uf), .reset_pin_i(rst_pin),
      .sleep_cmd_i(cmd), .clk_ctrl_o(clk_o), .asleep_o(asl), .wake_kind_o(kind),
      .wake_pulse_o(pls));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic go(input logic [15:0] c, input logic [15:0] g, input logic [4:0] e);
      @(posedge ref_clk);
      cs <= c;
      igc <= g;
      @(posedge ref_clk);
      cmd <= 1'b1;
      @(posedge ref_clk);
      cmd <= 1'b0;
      #1 chk({7'h00, asl}, 8'h01);
      chk({3'h0, clk_o}, {3'h0, e});
   endtask
   task automatic stay(input int n);
      repeat (n) @(posedge ref_clk);
      #1 chk({7'h00, asl}, 8'h01);
   endtask
   task automatic wake(input int n, input logic [1:0] k);
      #1;
      for (int i = 0; i < n && asl === 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      if (asl !== 1'b0) begin
         chk({7'h00, asl}, 8'h00);
         print_verdict();
      end
      chk({6'h00, kind}, {6'h00, k});
      chk({7'h00, pls}, 8'h01);
   endtask
   task automatic tmr();
      @(posedge ref_clk);
      uf[0] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      uf[0] <= 1'b0;
   endtask
   task automatic pin_to(input logic v);
      @(posedge ref_clk);
      pin[0] <= v;
   endtask
   task automatic rpin_wake();
      @(posedge ref_clk);
      rst_pin <= 1'b1;
      wake(10, 2'd1);
      @(posedge ref_clk);
      rst_pin <= 1'b0;
   endtask
   initial begin
      {cs, igc, dac, glb, dac_uf, rst_pin, cmd, msk_t, src, ten, uf} = '0;
      {msk_p, rise, pin} = '0;
      err_total = 0;
      check_count = 0;
      sys_rst = 1'b1;
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1 chk({3'h0, clk_o}, 8'h1F);
      chk({6'h00, kind}, 8'h00);
      $display("reset test done");
      @(posedge ref_clk);
      {glb, msk_t, src, ten, msk_p, rise} <= {1'b1, 2'b01, 2'b01, 2'b11, 12'h001, 12'h001};
      go(16'h0200, 16'h0000, 5'h0F);
      @(posedge ref_clk);
      dac_uf <= 1'b1;
      stay(8);
      @(posedge ref_clk);
      dac_uf <= 1'b0;
      tmr();
      wake(50, 2'd2);
      $display("light test done");
      @(posedge ref_clk);
      glb <= 1'b0;
      go(16'h0600, 16'h4000, 5'h01);
      tmr();
      stay(10);
      pin_to(1'b1);
      stay(40);
      wake(200, 2'd3);
      $display("mid test done");
      @(posedge ref_clk);
      {src, rise} <= '0;
      go(16'h0400, 16'h4000, 5'h00);
      tmr();
      stay(10);
      pin_to(1'b0);
      wake(200, 2'd3);
      $display("deep test done");
      @(posedge ref_clk);
      rise <= 12'h001;
      go(16'h0600, 16'h0000, 5'h01);
      pin_to(1'b1);
      stay(20);
      rpin_wake();
      $display("stop without async test done");
      {msk_p, pin} <= '0;
      go(16'h0100, 16'h0000, 5'h0F);
      pin_to(1'b1);
      stay(10);
      rpin_wake();
      $display("mask test done");
      print_verdict();
   end
endmodule // test_sleep_mode_wake_control
`default_nettype wire
